// [rtl/psp_top.sv]
// Purpose: parallel slave port with wishbone register access
// Assumes: clk_i 200 MHz; external strobes asynchronous
// Notes:   rst_i synchronous active high
`timescale 1ns/1ps
`include "psp_defines.svh"
module psp_top
    import psp_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [9:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // data port pins
    input  wire logic [7:0]  data_pin_i,
    output logic      [7:0]  data_pin_o,
    output logic      [7:0]  data_pin_oe_n_o,
    // control port pins: read, write, select strobes in slave mode
    input  wire logic [2:0]  ctrl_pin_i,
    output logic      [2:0]  ctrl_pin_o,
    output logic      [2:0]  ctrl_pin_oe_n_o,
    // interrupt
    output logic             irq_o
);

    typedef struct packed {
        logic [7:0]  out_latch;
        logic [7:0]  in_latch;
        logic [7:0]  data_dir;
        logic [2:0]  ctrl_latch;
        logic [2:0]  ctrl_dir;
        logic        slave_port_select;
        logic        input_full_flag;
        logic        output_full_flag;
        logic        input_overrun_flag;
        logic [6:0]  irq_flags_lo;
        logic        slave_port_irq_flag;
        logic [7:0]  irq_enables;
        logic [3:0]  analog_config_bits;
        logic [1:0]  phase;
        psp_xfer_e   wr_st;
        psp_xfer_e   rd_st;
        logic        wr_seen_q2;
        logic        rd_seen_q2;
        logic [31:0] dat;
        logic        ack;
        logic [7:0]  pin_o;
        logic [7:0]  pin_oe_n;
        logic [2:0]  cpin_oe_n;
        logic        irq;
    } psp_state_s;

    psp_state_s  cur_ff;
    psp_state_s  nxt_cur;
    logic [7:0]  pin_sync;
    psp_strobe_s stb_sync;

    // low byte of the 32-bit data when sel bit 0 is set, else the old byte
    function automatic logic [7:0] wb_byte(input logic [31:0] d, input logic [3:0] s,
                                           input logic [7:0] old);
        wb_byte = s[0] ? d[7:0] : old;
    endfunction

    // strobe synchroniser
    // pin 0 read, pin 1 write, pin 2 select; struct is {rd_n, wr_n, cs_n}
    psp_sync #(.W(11)) i_psp_sync (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .async_i   ({ctrl_pin_i[0], ctrl_pin_i[1], ctrl_pin_i[2], data_pin_i}),
        .rst_val_i (11'h7ff),
        .sync_o    ({stb_sync, pin_sync})
    );

    logic        req;
    logic [7:0]  idx;
    logic        wr_act;
    logic        rd_act;
    logic        ph2;
    logic        ph4;
    logic        port_mode;
    logic        digital;
    logic        irq_set;

    always_comb begin
        req       = cyc_i && stb_i && !cur_ff.ack;
        idx       = adr_i[9:2];
        wr_act    = !stb_sync.cs_n && !stb_sync.wr_n;
        rd_act    = !stb_sync.cs_n && !stb_sync.rd_n;
        ph2       = (cur_ff.phase == `PSP_PHASE_TWO);
        ph4       = (cur_ff.phase == `PSP_PHASE_FOUR);
        // strobes only work when pins are digital inputs
        digital   = (cur_ff.analog_config_bits != 4'h0) && (cur_ff.ctrl_dir == 3'h7);
        port_mode = cur_ff.slave_port_select && digital;
        irq_set   = 1'b0;

        nxt_cur       = cur_ff;
        nxt_cur.phase = cur_ff.phase + 2'h1;
        nxt_cur.ack   = req;
        nxt_cur.dat   = 32'h0;

        // write capture while select and write low
        case (cur_ff.wr_st)
            PSP_IDLE: begin
                if (port_mode && wr_act) begin
                    nxt_cur.wr_st = PSP_BUSY;
                end
            end
            PSP_BUSY: begin
                nxt_cur.in_latch = pin_sync;
                if (!wr_act) begin
                    nxt_cur.wr_st      = PSP_DONE;
                    nxt_cur.wr_seen_q2 = 1'b0;
                end
            end
            PSP_DONE: begin
                if (ph2) begin
                    nxt_cur.wr_seen_q2 = 1'b1;
                end
                // flags on phase four after phase two
                if (ph4 && cur_ff.wr_seen_q2) begin
                    nxt_cur.wr_st               = PSP_IDLE;
                    nxt_cur.slave_port_irq_flag = 1'b1;
                    irq_set                     = 1'b1;
                    if (cur_ff.input_full_flag) begin
                        nxt_cur.input_overrun_flag = 1'b1;
                    end
                    nxt_cur.input_full_flag = 1'b1;
                end
            end
            default: nxt_cur.wr_st = PSP_IDLE;
        endcase

        // read handshake
        case (cur_ff.rd_st)
            PSP_IDLE: begin
                if (port_mode && rd_act) begin
                    nxt_cur.rd_st            = PSP_BUSY;
                    nxt_cur.output_full_flag = 1'b0;
                end
            end
            PSP_BUSY: begin
                if (!rd_act) begin
                    nxt_cur.rd_st      = PSP_DONE;
                    nxt_cur.rd_seen_q2 = 1'b0;
                end
            end
            PSP_DONE: begin
                if (ph2) begin
                    nxt_cur.rd_seen_q2 = 1'b1;
                end
                if (ph4 && cur_ff.rd_seen_q2) begin
                    nxt_cur.rd_st               = PSP_IDLE;
                    nxt_cur.slave_port_irq_flag = 1'b1;
                    irq_set                     = 1'b1;
                end
            end
            default: nxt_cur.rd_st = PSP_IDLE;
        endcase

        // register access; hardware sets above win over clears
        if (req) begin
            case (idx)
                `PSP_IDX_DATA_PORT: begin
                    if (we_i) begin
                        nxt_cur.out_latch = wb_byte(dat_i, sel_i, cur_ff.out_latch);
                        if (sel_i[0] && cur_ff.slave_port_select) begin
                            nxt_cur.output_full_flag = 1'b1;
                        end
                    end else begin
                        nxt_cur.dat[7:0] = cur_ff.slave_port_select ? cur_ff.in_latch
                                                                    : pin_sync;
                        // this read or leaving slave mode clears input full
                        if (!(cur_ff.wr_st == PSP_DONE && ph4 && cur_ff.wr_seen_q2)) begin
                            nxt_cur.input_full_flag = 1'b0;
                        end
                    end
                end
                `PSP_IDX_CTRL_PORT: begin
                    if (we_i && sel_i[0]) begin
                        nxt_cur.ctrl_latch = dat_i[2:0];
                    end
                    nxt_cur.dat[2:0] = digital ? {stb_sync.cs_n, stb_sync.wr_n, stb_sync.rd_n}
                                               : 3'h0;
                end
                `PSP_IDX_IRQ_FLAGS: begin
                    if (we_i && sel_i[0]) begin
                        nxt_cur.irq_flags_lo = dat_i[6:0];
                        // sticky; writing zero clears, a same-cycle set wins
                        nxt_cur.slave_port_irq_flag = dat_i[`PSP_BIT_IRQ] | irq_set;
                    end
                    nxt_cur.dat[7:0] = {cur_ff.slave_port_irq_flag, cur_ff.irq_flags_lo};
                end
                `PSP_IDX_CTRL_STATUS: begin
                    if (we_i && sel_i[0]) begin
                        nxt_cur.slave_port_select = dat_i[`PSP_BIT_SELECT];
                        nxt_cur.ctrl_dir          = dat_i[2:0];
                        // overrun only cleared by firmware writing zero
                        if (!dat_i[`PSP_BIT_OVERRUN]) begin
                            nxt_cur.input_overrun_flag = nxt_cur.input_overrun_flag
                                && (cur_ff.wr_st == PSP_DONE && ph4 && cur_ff.wr_seen_q2
                                    && cur_ff.input_full_flag);
                        end
                    end
                    nxt_cur.dat[7:0] = {cur_ff.input_full_flag, cur_ff.output_full_flag,
                                        cur_ff.input_overrun_flag, cur_ff.slave_port_select,
                                        1'b0, cur_ff.ctrl_dir};
                end
                `PSP_IDX_IRQ_ENABLES: begin
                    if (we_i && sel_i[0]) begin
                        nxt_cur.irq_enables = dat_i[7:0];
                    end
                    nxt_cur.dat[7:0] = cur_ff.irq_enables;
                end
                `PSP_IDX_ANALOG_CFG: begin
                    if (we_i && sel_i[0]) begin
                        nxt_cur.analog_config_bits = dat_i[3:0];
                    end
                    nxt_cur.dat[3:0] = cur_ff.analog_config_bits;
                end
                // data direction kept at index 0x88, used for the pins outside port mode
                8'h88: begin
                    if (we_i && sel_i[0]) begin
                        nxt_cur.data_dir = dat_i[7:0];
                    end
                    nxt_cur.dat[7:0] = cur_ff.data_dir;
                end
                default: nxt_cur.dat = 32'h0;
            endcase
        end

        // full flags held clear outside slave mode
        if (!cur_ff.slave_port_select) begin
            nxt_cur.input_full_flag  = 1'b0;
            nxt_cur.output_full_flag = 1'b0;
            nxt_cur.wr_st            = PSP_IDLE;
            nxt_cur.rd_st            = PSP_IDLE;
        end

        // in port mode drive pins only during selected read; otherwise data_dir sets the drive
        if (port_mode) begin
            nxt_cur.pin_o    = nxt_cur.out_latch;
            nxt_cur.pin_oe_n = rd_act ? 8'h00 : 8'hff;
        end else begin
            nxt_cur.pin_o    = nxt_cur.out_latch;
            nxt_cur.pin_oe_n = nxt_cur.data_dir;
        end
        // control pins inputs in slave mode
        nxt_cur.cpin_oe_n = nxt_cur.slave_port_select ? 3'h7 : nxt_cur.ctrl_dir;

        nxt_cur.irq = (nxt_cur.slave_port_irq_flag && nxt_cur.irq_enables[`PSP_BIT_IRQ])
                    || |(nxt_cur.irq_flags_lo & nxt_cur.irq_enables[6:0]);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cur_ff                     <= '0;
            cur_ff.data_dir            <= 8'hff;
            cur_ff.ctrl_dir            <= 3'(`PSP_RST_CTRL_STATUS);
            cur_ff.irq_enables         <= `PSP_RST_IRQ_ENABLES;
            cur_ff.analog_config_bits  <= 4'h0;
            cur_ff.wr_st               <= PSP_IDLE;
            cur_ff.rd_st               <= PSP_IDLE;
            cur_ff.pin_oe_n            <= 8'hff;
            cur_ff.cpin_oe_n           <= 3'h7;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    assign dat_o           = cur_ff.dat;
    assign ack_o           = cur_ff.ack;
    assign data_pin_o      = cur_ff.pin_o;
    assign data_pin_oe_n_o = cur_ff.pin_oe_n;
    assign ctrl_pin_o      = cur_ff.ctrl_latch;
    assign ctrl_pin_oe_n_o = cur_ff.cpin_oe_n;
    assign irq_o           = cur_ff.irq;

endmodule

// [rtl/psp_defines.svh]
// Purpose: offsets, field positions, reset values and phase codes for the slave port
// Assumes: wishbone byte addresses are four times the register index
// Notes:   definitions only
`ifndef PSP_DEFINES_SVH
`define PSP_DEFINES_SVH

// register indices
`define PSP_IDX_DATA_PORT     8'h08
`define PSP_IDX_CTRL_PORT     8'h09
`define PSP_IDX_IRQ_FLAGS     8'h0c
`define PSP_IDX_CTRL_STATUS   8'h89
`define PSP_IDX_IRQ_ENABLES   8'h8c
`define PSP_IDX_ANALOG_CFG    8'h9f

// slave_port_control_status fields
`define PSP_BIT_IN_FULL       7
`define PSP_BIT_OUT_FULL      6
`define PSP_BIT_OVERRUN       5
`define PSP_BIT_SELECT        4
// irq flag / enable bit
`define PSP_BIT_IRQ           7

// reset values
`define PSP_RST_CTRL_STATUS   8'h07
`define PSP_RST_IRQ_FLAGS     8'h00
`define PSP_RST_IRQ_ENABLES   8'h00
`define PSP_RST_ANALOG_CFG    8'h00

// four-phase instruction clock: codes of phases two and four
`define PSP_PHASE_TWO         2'h1
`define PSP_PHASE_FOUR        2'h3

`endif

// [rtl/psp_pkg.sv]
// Purpose: types shared by the slave port files
// Assumes: nothing
// Notes:   constants live in psp_defines.svh
package psp_pkg;

    typedef enum logic [2:0] {
        PSP_IDLE  = 3'b001,
        PSP_BUSY  = 3'b010,
        PSP_DONE  = 3'b100
    } psp_xfer_e;

    typedef struct packed {
        logic       rd_n;
        logic       wr_n;
        logic       cs_n;
    } psp_strobe_s;

    typedef struct packed {
        logic [7:0] dat;
        logic [7:0] oe_n;
    } psp_data_pins_s;

endpackage

// [rtl/psp_sync.sv]
// Purpose: two-stage synchroniser for a group of pin inputs
// Assumes: inputs are asynchronous to clk_i
// Notes:   stage one feeds stage two only
`timescale 1ns/1ps
module psp_sync #(
    parameter int W = 3
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // pins in, synchronised out
    input  wire logic [W-1:0] async_i,
    input  wire logic [W-1:0] rst_val_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] meta_ff;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_ff <= rst_val_i;
            sync_o  <= rst_val_i;
        end else begin
            meta_ff <= async_i;
            sync_o  <= meta_ff;
        end
    end
endmodule

// [verif/psp_top_assertions.sv]
// Purpose: port checks for psp_top
// Assumes: mode and enable change only by wishbone writes
// Notes:   bound to psp_top below
`timescale 1ns/1ps
`include "psp_defines.svh"
module psp_top_checker (
    // clock, reset, bus
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [9:0]  adr_i,
    input wire logic [3:0]  sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    // pins
    input wire logic [2:0]  ctrl_pin_i,
    input wire logic [7:0]  data_pin_oe_n_o,
    input wire logic        irq_o
);
    logic [7:0] idx;
    logic       rd_act;
    logic       wr_act;
    logic       wr_ev;
    logic       mapped;
    logic       mode_ff;
    logic       en_ff;
    assign idx    = adr_i[9:2];
    assign rd_act = !ctrl_pin_i[0] && !ctrl_pin_i[2];
    assign wr_act = !ctrl_pin_i[1] && !ctrl_pin_i[2];
    // taken at the same edge as the design applies the write
    assign wr_ev  = cyc_i && stb_i && !ack_o && we_i && sel_i[0];
    assign mapped = idx inside {`PSP_IDX_DATA_PORT, `PSP_IDX_CTRL_PORT, `PSP_IDX_IRQ_FLAGS,
                                `PSP_IDX_CTRL_STATUS, `PSP_IDX_IRQ_ENABLES,
                                `PSP_IDX_ANALOG_CFG, 8'h88};
    // snooped copies, no port shows them
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_ff <= 1'b0;
            en_ff   <= 1'b0;
        end else begin
            if (wr_ev && idx == `PSP_IDX_CTRL_STATUS) begin
                mode_ff <= dat_i[`PSP_BIT_SELECT];
            end
            if (wr_ev && idx == `PSP_IDX_IRQ_ENABLES) begin
                en_ff <= dat_i[`PSP_BIT_IRQ];
            end
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence take_s;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence rd_held_s;
        rd_act [*6];
    endsequence
    ack_next_a: assert property (take_s |=> ack_o) else $error("no ack");
    ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack too long");
    dat_upper_a: assert property (ack_o |-> dat_o[31:8] == 24'h0) else $error("upper data");
    unmapped_zero_a: assert property (ack_o && !we_i && !mapped |-> dat_o == 32'h0)
        else $error("unmapped read");
    drive_whole_a: assert property (mode_ff |-> data_pin_oe_n_o inside {8'h00, 8'hff})
        else $error("partial drive");
    drive_cause_a: assert property (mode_ff && data_pin_oe_n_o == 8'h00 |-> rd_act
        || $past(rd_act) || $past(rd_act, 2) || $past(rd_act, 3) || $past(rd_act, 4))
        else $error("drive without read");
    read_drive_a: assert property (rd_held_s ##0 mode_ff |-> data_pin_oe_n_o == 8'h00)
        else $error("read not driven");
    sync_delay_a: assert property (mode_ff && $rose(rd_act) |->
        data_pin_oe_n_o == 8'hff ##1 data_pin_oe_n_o == 8'hff) else $error("unsynced");
    irq_raise_a: assert property (mode_ff && en_ff && ($fell(wr_act) || $fell(rd_act))
        |-> ##[1:14] irq_o) else $error("no irq after transfer");
    irq_gate_a: assert property (!en_ff && !$past(en_ff) |-> !irq_o)
        else $error("masked irq");
endmodule
bind psp_top psp_top_checker i_psp_top_checker (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .ctrl_pin_i(ctrl_pin_i), .data_pin_oe_n_o(data_pin_oe_n_o), .irq_o(irq_o)
);

// [verif/psp_ext_cpu.sv]
// Purpose: outside processor on the data and strobe pins
// Assumes: strobes {select, write, read} on bits 2..0, active low
// Notes:   data held past release so the synchronised capture sees it
`timescale 1ns/1ps
module psp_ext_cpu (
    // clock
    input  wire logic       clk_i,
    // device pins
    input  wire logic [7:0] data_pin_o,
    input  wire logic [7:0] data_pin_oe_n_o,
    input  wire logic [2:0] ctrl_pin_o,
    input  wire logic [2:0] ctrl_pin_oe_n_o,
    // resolved wires
    output logic      [7:0] data_wire_o,
    output logic      [2:0] ctrl_wire_o
);
    logic       busy_ff   = 1'b0;
    logic [7:0] drv_ff    = 8'h00;
    logic [2:0] strobe_ff = 3'b111;
    logic [7:0] src;
    // released bus shows the inverse, not a stale byte
    always_comb begin
        src = busy_ff ? drv_ff : ~drv_ff;
        for (int i = 0; i < 8; i++) begin
            data_wire_o[i] = data_pin_oe_n_o[i] ? src[i] : data_pin_o[i];
        end
        for (int i = 0; i < 3; i++) begin
            ctrl_wire_o[i] = ctrl_pin_oe_n_o[i] ? strobe_ff[i] : ctrl_pin_o[i];
        end
    end
    task automatic xwrite(input logic [7:0] v);
        busy_ff <= 1'b1;
        drv_ff  <= v;
        @(posedge clk_i);
        strobe_ff <= 3'b001;
        repeat (8) @(posedge clk_i);
        strobe_ff <= 3'b111;
        repeat (4) @(posedge clk_i);
        busy_ff <= 1'b0;
        repeat (12) @(posedge clk_i);
    endtask
    task automatic xread(output logic [7:0] v);
        strobe_ff <= 3'b010;
        repeat (8) @(posedge clk_i);
        v = data_wire_o;
        strobe_ff <= 3'b111;
        repeat (14) @(posedge clk_i);
    endtask
endmodule

// [verif/test_psp_top.sv]
// Purpose: self-checking bench for psp_top
// Assumes: byte address is four times the index
// Notes:   one task per scenario
`timescale 1ns/1ps
`include "psp_defines.svh"
module test_psp_top
    import psp_pkg::*;
;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc_i = 1'b0;
    logic        stb_i = 1'b0;
    logic        we_i  = 1'b0;
    logic [9:0]  adr_i = 10'h000;
    logic [3:0]  sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o;
    logic        ack_o;
    logic        irq_o;
    logic [7:0]  pin_d, pin_q, pin_oe_n, b;
    logic [2:0]  pin_c, cq, coe_n;
    int          miscompares = 0;
    int          compares    = 0;
    int          cycles      = 0;
    psp_top i_psp_top (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .data_pin_i(pin_d), .data_pin_o(pin_q), .data_pin_oe_n_o(pin_oe_n),
        .ctrl_pin_i(pin_c), .ctrl_pin_o(cq), .ctrl_pin_oe_n_o(coe_n), .irq_o(irq_o));
    psp_ext_cpu i_psp_ext_cpu (.clk_i(clk_i), .data_pin_o(pin_q), .data_pin_oe_n_o(pin_oe_n),
        .ctrl_pin_o(cq), .ctrl_pin_oe_n_o(coe_n), .data_wire_o(pin_d), .ctrl_wire_o(pin_c));
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
        int n;
        n = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        sel_i <= 4'h1;
        adr_i <= {idx, 2'b00};
        dat_i <= {24'h0, wd};
        while (ack_o !== 1'b1 && n < 40) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 40) miscompares++;
        b = dat_o[7:0];
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rdchk(input string what, input logic [7:0] idx, input logic [7:0] exp);
        wb(1'b0, idx, 8'h00);
        check(what, b, exp);
    endtask
    task automatic t_reset();
        rdchk("status", `PSP_IDX_CTRL_STATUS, `PSP_RST_CTRL_STATUS);
        rdchk("flags", `PSP_IDX_IRQ_FLAGS, `PSP_RST_IRQ_FLAGS);
        rdchk("enables", `PSP_IDX_IRQ_ENABLES, `PSP_RST_IRQ_ENABLES);
        rdchk("analog", `PSP_IDX_ANALOG_CFG, `PSP_RST_ANALOG_CFG);
        wb(1'b1, 8'h40, 8'h5a);
        rdchk("unmapped", 8'h40, 8'h00);
        wb(1'b1, `PSP_IDX_CTRL_PORT, 8'h05);
        check("ctrl latch", {5'h0, cq}, 8'h05);
        check("idle drive", pin_oe_n, 8'hff);
    endtask
    task automatic t_write();
        wb(1'b1, `PSP_IDX_ANALOG_CFG, 8'h07);
        wb(1'b1, `PSP_IDX_CTRL_STATUS, 8'h10);
        check("ctrl inputs", {5'h0, coe_n}, 8'h07);
        wb(1'b1, `PSP_IDX_CTRL_STATUS, 8'h17);
        wb(1'b1, `PSP_IDX_IRQ_ENABLES, 8'h80);
        i_psp_ext_cpu.xwrite(8'ha5);
        rdchk("in full", `PSP_IDX_CTRL_STATUS, 8'h97);
        rdchk("status kept", `PSP_IDX_CTRL_STATUS, 8'h97);
        check("irq", {7'h0, irq_o}, 8'h01);
        rdchk("write flag", `PSP_IDX_IRQ_FLAGS, 8'h80);
        rdchk("in latch", `PSP_IDX_DATA_PORT, 8'ha5);
        rdchk("in drained", `PSP_IDX_CTRL_STATUS, 8'h17);
        i_psp_ext_cpu.xwrite(8'h3c);
        i_psp_ext_cpu.xwrite(8'h5a);
        rdchk("overrun", `PSP_IDX_CTRL_STATUS, 8'hb7);
        wb(1'b1, `PSP_IDX_IRQ_FLAGS, 8'h00);
        repeat (2) @(posedge clk_i);
        check("irq cleared", {7'h0, irq_o}, 8'h00);
    endtask
    task automatic t_read();
        wb(1'b1, `PSP_IDX_IRQ_ENABLES, 8'h00);
        wb(1'b1, `PSP_IDX_DATA_PORT, 8'hc3);
        rdchk("out full", `PSP_IDX_CTRL_STATUS, 8'hf7);
        i_psp_ext_cpu.xread(b);
        check("ext read", b, 8'hc3);
        rdchk("out empty", `PSP_IDX_CTRL_STATUS, 8'hb7);
        rdchk("read flag", `PSP_IDX_IRQ_FLAGS, 8'h80);
        check("masked", {7'h0, irq_o}, 8'h00);
        wb(1'b1, `PSP_IDX_IRQ_ENABLES, 8'h80);
        repeat (2) @(posedge clk_i);
        check("unmasked", {7'h0, irq_o}, 8'h01);
        rdchk("still empty", `PSP_IDX_CTRL_STATUS, 8'hb7);
    endtask
    task automatic t_mode_off();
        wb(1'b1, `PSP_IDX_DATA_PORT, 8'h11);
        wb(1'b1, `PSP_IDX_CTRL_STATUS, 8'h27);
        rdchk("mode off", `PSP_IDX_CTRL_STATUS, 8'h27);
        i_psp_ext_cpu.xwrite(8'h66);
        rdchk("no capture", `PSP_IDX_CTRL_STATUS, 8'h27);
        wb(1'b1, `PSP_IDX_CTRL_STATUS, 8'h07);
        rdchk("overrun off", `PSP_IDX_CTRL_STATUS, 8'h07);
    endtask
    always #2.5 clk_i = ~clk_i;
    // whole run needs well under a thousand cycles
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            end_of_test();
        end
    end
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset();
        t_write();
        t_read();
        t_mode_off();
        end_of_test();
    end
endmodule
